// file: inc/stp_pkg.sv
// package for the standard timer pulse / capture block: register map and field constants
package stp_pkg;
    // -----------------------------------------------------------------
    // register offsets (byte addresses, one 8-bit register per address)
    // -----------------------------------------------------------------
    localparam logic [3:0] ADDR_CTRL0   = 4'h0; // run bit, ext-trigger enable
    localparam logic [3:0] ADDR_CTRL1   = 4'h1; // mode, pin function, level, swap
    localparam logic [3:0] ADDR_CNT_LO  = 4'h2; // counter bits 7..0 (read only)
    localparam logic [3:0] ADDR_CNT_HI  = 4'h3; // counter bits 15..8 (read only)
    localparam logic [3:0] ADDR_CMPA_LO = 4'h4; // compare A bits 7..0
    localparam logic [3:0] ADDR_CMPA_HI = 4'h5; // compare A bits 15..8
    localparam logic [3:0] ADDR_CMPP    = 4'h6; // compare P, 8 bits
    localparam logic [3:0] ADDR_STATUS  = 4'h7; // event flags, write 1 to clear

    // -----------------------------------------------------------------
    // field positions
    // -----------------------------------------------------------------
    localparam int C0_RUN      = 3; // counter_run_bit
    localparam int C0_EXT_EN   = 0; // ext_clock_pin trigger enable
    localparam int C1_MODE_HI  = 7; // mode_select_hi
    localparam int C1_MODE_LO  = 6; // mode_select_lo
    localparam int C1_PIN_HI   = 5; // pin_function_hi
    localparam int C1_PIN_LO   = 4; // pin_function_lo
    localparam int C1_INIT_LVL = 3; // output_initial_level
    localparam int C1_INVERT   = 2; // output_invert
    localparam int C1_SWAP     = 1; // pwm_role_swap
    localparam int C1_CLR_SEL  = 0; // counter_clear_select
    localparam int ST_A_FLAG   = 0; // compare A match or capture event
    localparam int ST_P_FLAG   = 1; // compare P match event

    // -----------------------------------------------------------------
    // reset values and field encodings
    // -----------------------------------------------------------------
    localparam logic [7:0]  RST_BYTE    = 8'h00;
    localparam logic [15:0] RST_WORD    = 16'h0000;
    localparam logic [1:0]  MODE_CMP    = 2'h0;
    localparam logic [1:0]  MODE_CAP    = 2'h1;
    localparam logic [1:0]  MODE_PWM    = 2'h2;
    localparam logic [1:0]  MODE_TMR    = 2'h3;
    localparam logic [1:0]  PIN_INACT   = 2'h0; // pwm forced inactive / capture rising
    localparam logic [1:0]  PIN_ACT     = 2'h1; // pwm forced active / capture falling
    localparam logic [1:0]  PIN_PWM     = 2'h2; // pwm output / capture both edges
    localparam logic [1:0]  PIN_PULSE   = 2'h3; // single pulse / capture disabled
    localparam logic [15:0] CNT_MAX     = 16'hFFFF;
    localparam logic [7:0]  CMPP_ZERO   = 8'h00;
    localparam logic [7:0]  TMR_DIV     = 8'h04; // timer tick = system clock / 4
endpackage

// file: rtl/stp_timer.sv
// 16-bit standard timer: swapped-role pwm, single pulse output and capture input
module stp_timer
    import stp_pkg::*;
(
    input  wire logic       clk_sys_i,     // system clock, 100 MHz
    input  wire logic       rst_n_i,       // asynchronous reset, active low
    input  wire logic [3:0] addr_i,        // register address
    input  wire logic [7:0] wdata_i,       // write data
    input  wire logic       wr_i,          // write strobe
    input  wire logic       rd_i,          // read strobe
    input  wire logic       ext_clock_pin_i,     // external trigger pin
    input  wire logic       capture_input_pin_i, // capture input pin
    output logic      [7:0] rdata_o,       // read data, cycle after strobe
    output logic            timer_out_o,   // timer output pin
    output logic            timer_irq_o    // one-cycle interrupt request pulse
);
    import stp_pkg::*;

    // -----------------------------------------------------------------
    // reset release and pin synchronisers
    // -----------------------------------------------------------------
    logic [1:0] rst_sync;     // reset release chain
    logic       rst_n;        // synchronised reset
    logic [1:0] ext_sync;     // ext pin chain
    logic [1:0] cap_sync;     // capture pin chain
    logic       ext_prev;     // previous synchronised ext pin
    logic       cap_prev;     // previous synchronised capture pin

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            rst_sync <= 2'h0;
        else
            rst_sync <= {rst_sync[0], 1'b1};
    end
    assign rst_n = rst_sync[1];

    // two-flop synchronisers, then a third flop for edge detection
    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ext_sync <= 2'h0;
            cap_sync <= 2'h0;
            ext_prev <= 1'b0;
            cap_prev <= 1'b0;
        end
        else
        begin
            ext_sync <= {ext_sync[0], ext_clock_pin_i};
            cap_sync <= {cap_sync[0], capture_input_pin_i};
            ext_prev <= ext_sync[1];
            cap_prev <= cap_sync[1];
        end
    end

    // -----------------------------------------------------------------
    // registers
    // -----------------------------------------------------------------
    logic [7:0]  ctrl0;        // run bit and trigger enable
    logic [7:0]  ctrl1;        // mode and pin configuration
    logic [15:0] counter;      // main up counter
    logic [15:0] cmp_a;        // compare A / capture value
    logic [7:0]  cmp_p;        // compare P
    logic [1:0]  flags;        // sticky event flags
    logic        run_prev;     // run bit last cycle
    logic [7:0]  div_cnt;      // tick divider
    logic        tick;         // timer clock enable pulse
    logic        out_q;        // output level

    // -----------------------------------------------------------------
    // decode
    // -----------------------------------------------------------------
    wire [1:0] mode      = {ctrl1[C1_MODE_HI], ctrl1[C1_MODE_LO]};
    wire [1:0] pin_fn    = {ctrl1[C1_PIN_HI], ctrl1[C1_PIN_LO]};
    wire       run       = ctrl0[C0_RUN];
    wire       run_rise  = run & ~run_prev;
    wire       is_pwm    = (mode == MODE_PWM) && (pin_fn != PIN_PULSE);
    wire       is_pulse  = (mode == MODE_PWM) && (pin_fn == PIN_PULSE);
    wire       is_cap    = (mode == MODE_CAP);
    wire       swap      = ctrl1[C1_SWAP];
    wire       act_lvl   = ~ctrl1[C1_INIT_LVL] ^ ctrl1[C1_INVERT];
    wire       init_lvl  = ctrl1[C1_INIT_LVL];

    // compare P against the high byte; zero means full 65536 count
    function automatic logic p_match(input logic [15:0] cnt, input logic [7:0] p);
        if (p == CMPP_ZERO)
            return cnt == CNT_MAX;
        else
            return (cnt[15:8] == p - 8'h01) && (cnt[7:0] == 8'hFF);
    endfunction

    wire       cnt_en    = run & tick;
    wire       a_hit     = cnt_en && (counter == cmp_a);
    wire       p_hit     = cnt_en && p_match(counter, cmp_p);
    // pwm clear chosen by swap bit only, counter_clear_select ignored
    wire       pwm_clr   = swap ? a_hit : p_hit;
    wire       cap_edge  = (cap_sync[1] ^ cap_prev) &&
                           ((pin_fn == PIN_PWM) ||
                            (pin_fn == PIN_INACT && cap_sync[1]) ||
                            (pin_fn == PIN_ACT && !cap_sync[1]));
    wire       do_cap    = is_cap && run && cap_edge;
    wire       ext_trig  = is_pulse && ctrl0[C0_EXT_EN] && ext_sync[1] && !ext_prev;
    wire       pulse_end = is_pulse && a_hit;
    // duty: swapped uses P*256 with zero meaning 65536, else compare A
    wire [16:0] duty     = swap ? ((cmp_p == CMPP_ZERO) ? 17'h10000 : {1'b0, cmp_p, 8'h00})
                                : {1'b0, cmp_a};
    wire       pwm_act   = {1'b0, counter} < duty;
    wire       wr_ctrl0  = wr_i && (addr_i == ADDR_CTRL0);
    wire       ev_a      = (is_pulse && a_hit) || do_cap || (is_pwm && a_hit);
    wire       ev_p      = (is_cap && p_hit) || (is_pwm && p_hit);

    // -----------------------------------------------------------------
    // timer tick divider
    // -----------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            div_cnt <= RST_BYTE;
            tick    <= 1'b0;
        end
        else
        begin
            div_cnt <= (div_cnt == TMR_DIV - 8'h01) ? RST_BYTE : div_cnt + 8'h01;
            tick    <= (div_cnt == TMR_DIV - 8'h01);
        end
    end

    // -----------------------------------------------------------------
    // control registers; hardware sets/clears of run win over software
    // -----------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl0    <= RST_BYTE;
            ctrl1    <= RST_BYTE;
            cmp_p    <= RST_BYTE;
            run_prev <= 1'b0;
        end
        else
        begin
            run_prev <= run;
            if (wr_ctrl0)
                ctrl0 <= wdata_i;
            if (wr_i && addr_i == ADDR_CTRL1)
                ctrl1 <= wdata_i;
            if (wr_i && addr_i == ADDR_CMPP)
                cmp_p <= wdata_i;
            if (ext_trig)
                ctrl0[C0_RUN] <= 1'b1;
            else if (pulse_end)
                ctrl0[C0_RUN] <= 1'b0;
        end
    end

    // -----------------------------------------------------------------
    // counter and compare A / capture register
    // -----------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            counter <= RST_WORD;
            cmp_a   <= RST_WORD;
        end
        else
        begin
            // capture wins over a software write in the same cycle
            if (do_cap)
                cmp_a <= counter;
            else if (wr_i && addr_i == ADDR_CMPA_LO)
                cmp_a[7:0] <= wdata_i;
            else if (wr_i && addr_i == ADDR_CMPA_HI)
                cmp_a[15:8] <= wdata_i;
            // start from zero on every run rising edge
            if (run_rise)
                counter <= RST_WORD;
            else if (cnt_en)
            begin
                if (is_pwm && pwm_clr)
                    counter <= RST_WORD;
                else if (is_cap && p_hit)
                    counter <= RST_WORD;
                else if (!is_pwm && !is_cap && !is_pulse && !ctrl1[C1_CLR_SEL] && p_hit)
                    counter <= RST_WORD;
                else if (!is_pwm && !is_cap && !is_pulse && ctrl1[C1_CLR_SEL] && a_hit)
                    counter <= RST_WORD;
                else
                    counter <= counter + 16'h0001;
            end
        end
    end

    // -----------------------------------------------------------------
    // output pin, flags and interrupt
    // -----------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            out_q       <= 1'b0;
            flags       <= 2'h0;
            timer_irq_o <= 1'b0;
        end
        else
        begin
            timer_irq_o <= ev_a | ev_p;
            // set wins over a write-one-to-clear in the same cycle
            flags <= (flags & ~((wr_i && addr_i == ADDR_STATUS) ? wdata_i[1:0] : 2'h0))
                     | {ev_p, ev_a};
            if (is_cap)
                out_q <= out_q;
            else if (run_rise)
                out_q <= is_pulse ? act_lvl : init_lvl;
            else if (is_pulse && (pulse_end || (!run && run_prev)))
                out_q <= init_lvl ^ ctrl1[C1_INVERT];
            else if (is_pwm && pin_fn == PIN_INACT)
                out_q <= ~act_lvl;
            else if (is_pwm && pin_fn == PIN_ACT)
                out_q <= act_lvl;
            else if (is_pwm && run)
                out_q <= pwm_act ? act_lvl : ~act_lvl;
        end
    end
    assign timer_out_o = out_q;

    // -----------------------------------------------------------------
    // register read, data valid the cycle after the strobe
    // -----------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
            rdata_o <= RST_BYTE;
        else if (rd_i)
        begin
            unique case (addr_i)
                ADDR_CTRL0:   rdata_o <= ctrl0;
                ADDR_CTRL1:   rdata_o <= ctrl1;
                ADDR_CNT_LO:  rdata_o <= counter[7:0];
                ADDR_CNT_HI:  rdata_o <= counter[15:8];
                ADDR_CMPA_LO: rdata_o <= cmp_a[7:0];
                ADDR_CMPA_HI: rdata_o <= cmp_a[15:8];
                ADDR_CMPP:    rdata_o <= cmp_p;
                ADDR_STATUS:  rdata_o <= {6'h00, flags};
                default:      rdata_o <= RST_BYTE; // unmapped reads zero
            endcase
        end
        else
            rdata_o <= RST_BYTE;
    end
endmodule

// file: tb/stp_timer_asserts.sv
// checker for the timer: bus answers, pulse edges and capture events
module stp_timer_asserts
    import stp_pkg::*;
(
    input wire logic       clk_sys_i,
    input wire logic       rst_n_i,
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic       wr_i,
    input wire logic       rd_i,
    input wire logic       ext_clock_pin_i,
    input wire logic       capture_input_pin_i,
    input wire logic [7:0] rdata_o,
    input wire logic       timer_out_o,
    input wire logic       timer_irq_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    logic [7:0] ctrl1;  // shadow of control 1
    logic [7:0] cmpp;   // shadow of compare P
    wire        pulse_m = ctrl1[7:6] == MODE_PWM && ctrl1[5:4] == PIN_PULSE;
    wire        cap_m   = ctrl1[7:6] == MODE_CAP;
    wire        lead    = ~ctrl1[C1_INIT_LVL] ^ ctrl1[C1_INVERT];
    wire  [1:0] pf      = ctrl1[5:4];
    // shadows follow software writes
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ctrl1 <= RST_BYTE;
            cmpp  <= RST_BYTE;
        end
        else if (wr_i && addr_i == ADDR_CTRL1)
            ctrl1 <= wdata_i;
        else if (wr_i && addr_i == ADDR_CMPP)
            cmpp <= wdata_i;
    end
    sequence s_run_on;
        wr_i && addr_i == ADDR_CTRL0 && wdata_i[C0_RUN] && pulse_m;
    endsequence
    sequence s_run_off;
        wr_i && addr_i == ADDR_CTRL0 && !wdata_i[C0_RUN] && pulse_m;
    endsequence
    idle_rdata_a: assert property (!rd_i |=> rdata_o == 8'h00)
        else $error("read data not idle");
    unmapped_read_a: assert property (rd_i && addr_i[3] |=> rdata_o == 8'h00)
        else $error("unmapped read not zero");
    cmpp_read_a: assert property (rd_i && addr_i == ADDR_CMPP |=> rdata_o == cmpp)
        else $error("compare P readback wrong");
    ctrl1_read_a: assert property (rd_i && addr_i == ADDR_CTRL1 ##1 1 |-> rdata_o == $past(ctrl1))
        else $error("control 1 readback wrong");
    pulse_lead_a: assert property (s_run_on |-> ##[1:4] timer_out_o == lead)
        else $error("pulse leading edge missing");
    pulse_trail_a: assert property (s_run_off |-> ##[1:4] timer_out_o == !lead)
        else $error("pulse trailing edge missing");
    capture_irq_a: assert property (cap_m && (pf == PIN_INACT && $rose(capture_input_pin_i)
        || pf == PIN_ACT && $fell(capture_input_pin_i)
        || pf == PIN_PWM && $changed(capture_input_pin_i)) |-> ##[1:8] timer_irq_o)
        else $error("capture request missing");
    capture_hold_a: assert property (cap_m && $past(cap_m, 3) |-> $stable(timer_out_o))
        else $error("output moved in capture mode");
endmodule
bind stp_timer stp_timer_asserts u_chk (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .ext_clock_pin_i(ext_clock_pin_i), .capture_input_pin_i(capture_input_pin_i),
    .rdata_o(rdata_o), .timer_out_o(timer_out_o), .timer_irq_o(timer_irq_o));

// file: tb/stp_pins_model.sv
// model of the pins around the timer: trigger and capture sources, output watcher
module stp_pins_model
(
    input  wire logic clk_i,  // bench clock
    input  wire logic out_i,  // timer output pin
    input  wire logic irq_i,  // timer interrupt request
    output logic      ext_o,  // external trigger pin
    output logic      cap_o   // capture input pin
);
    timeunit 1ns;
    timeprecision 1ps;
    int irq_cnt = 0;  // interrupt pulses seen
    initial
    begin
        ext_o = 1'b0;
        cap_o = 1'b0;
    end
    // count interrupt pulses
    always @(posedge clk_i)
        if (irq_i === 1'b1)
            irq_cnt <= irq_cnt + 1;
    // one-cycle trigger pulse, both edges inside two cycles
    task automatic ext_pulse();
        @(posedge clk_i);
        ext_o <= 1'b1;
        @(posedge clk_i);
        ext_o <= 1'b0;
    endtask
    // capture pin level change
    task automatic set_cap(input logic v);
        @(posedge clk_i);
        cap_o <= v;
    endtask
    // wait for the output to reach lvl, then count cycles it stays there
    task automatic edge_len(input logic lvl, output int n);
        int w;
        w = 0;
        n = 0;
        while (out_i !== lvl && w < 20000)
        begin
            @(posedge clk_i);
            w++;
        end
        while (out_i === lvl && n < 20000)
        begin
            @(posedge clk_i);
            n++;
        end
    endtask
endmodule

// file: tb/stp_timer_test.sv
// self-checking bench for the timer: registers, pwm, single pulse, capture
module stp_timer_test;
    timeunit 1ns;
    timeprecision 1ps;
    import stp_pkg::*;
    logic       clk_sys_i = 1'b0;
    logic       rst_n_i   = 1'b0;
    logic [3:0] addr_i    = 4'h0;
    logic [7:0] wdata_i   = 8'h00;
    logic       wr_i      = 1'b0;
    logic       rd_i      = 1'b0;
    logic       rd_prev   = 1'b0;  // read strobe of the last cycle
    logic       ext_pin, cap_pin, out_pin, irq, lvl;
    logic [7:0] rdata, r8;
    logic [7:0] exp_q[$];          // expected read data, oldest first
    int         fail_count = 0;
    int         n_compared = 0;
    int         cycles     = 0;
    int         hi, lo, irq0;
    // pwm rows: swapped, plain, inverted, forced active, forced inactive
    logic [7:0]  pc1[5] = '{8'hA2, 8'hA0, 8'hA6, 8'h92, 8'h82};
    logic [15:0] pa[5]  = '{16'h0300, 16'h0200, 16'h0300, 16'h0300, 16'h0300};
    logic [7:0]  pp[5]  = '{8'h01, 8'h03, 8'h01, 8'h01, 8'h01};
    int          ph[3]  = '{1024, 2048, 2048};
    int          ci[4]  = '{1, 1, 2, 1};  // interrupts per capture row
    stp_timer uut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .ext_clock_pin_i(ext_pin),
        .capture_input_pin_i(cap_pin), .rdata_o(rdata), .timer_out_o(out_pin),
        .timer_irq_o(irq));
    stp_pins_model pins (.clk_i(clk_sys_i), .out_i(out_pin), .irq_i(irq),
        .ext_o(ext_pin), .cap_o(cap_pin));
    initial forever #5 clk_sys_i = ~clk_sys_i;
    task automatic results();
        if (fail_count == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (g !== e)
        begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, e, g);
        end
    endtask
    // within two timer ticks (8 cycles) either side counts as a match
    function automatic logic [15:0] near(input int g, input int e);
        return (g - e <= 8 && e - g <= 8) ? 16'(e) : 16'(g);
    endfunction
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clk_sys_i);
        wr_i    <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        @(posedge clk_sys_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clk_sys_i);
        rd_i   <= 1'b0;
    endtask
    // stop the counter, then load compare A, compare P and control 1
    task automatic setup(input logic [15:0] a, input logic [7:0] p, input logic [7:0] c1);
        wr(ADDR_CTRL0, RST_BYTE);
        wr(ADDR_CMPA_LO, a[7:0]);
        wr(ADDR_CMPA_HI, a[15:8]);
        wr(ADDR_CMPP, p);
        wr(ADDR_CTRL1, c1);
    endtask
    // read answers and the timeout
    always @(posedge clk_sys_i)
    begin
        rd_prev <= rd_i;
        cycles  <= cycles + 1;
        if (cycles == 60000)
        begin
            fail_count++;
            results();
        end
    end
    always @(negedge clk_sys_i)
        if (rd_prev)
            chk("rdata", {8'h00, exp_q.pop_front()}, {8'h00, rdata});
    initial
    begin
        void'($urandom(32'h4A9A));
        repeat (20) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        for (int a = 0; a < 16; a++)
            rd(4'(a), RST_BYTE);
        r8 = 8'($urandom);
        wr(ADDR_CMPP, r8);
        rd(ADDR_CMPP, r8);
        wr(ADDR_CNT_LO, ~r8);
        rd(ADDR_CNT_LO, RST_BYTE);
        for (int i = 0; i < 5; i++)
        begin
            setup(pa[i], pp[i], pc1[i] | 8'($urandom & 1));
            wr(ADDR_CTRL0, 8'h08);
            if (i < 3)
            begin
                pins.edge_len(1'b0, lo);
                pins.edge_len(1'b1, hi);
                pins.edge_len(1'b0, lo);
                chk("duty", 16'(ph[i]), near(hi, ph[i]));
                chk("period", 16'd3072, near(hi + lo, 3072));
            end
            else
            begin
                irq0 = pins.irq_cnt;
                repeat (1100) @(posedge clk_sys_i);
                chk("forced", 16'(i == 3), {15'h0, out_pin});
                chk("forced run", 16'h1, 16'(pins.irq_cnt > irq0));
            end
        end
        // single pulse twice by software, then from the trigger pin
        setup(16'h0010, 8'($urandom), 8'hB0 | 8'($urandom & 3));
        for (int k = 0; k < 3; k++)
        begin
            irq0 = pins.irq_cnt;
            if (k < 2)
                wr(ADDR_CTRL0, 8'h08);
            else
            begin
                // initial level and invert both set: idle pin stays low, pulse high
                wr(ADDR_CTRL1, 8'hBC);
                wr(ADDR_CTRL0, 8'h01);
                pins.ext_pulse();
            end
            pins.edge_len(1'b1, hi);
            repeat (4) @(posedge clk_sys_i);
            chk("width", 16'd64, near(hi, 64));
            chk("irq", 16'(irq0 + 1), 16'(pins.irq_cnt));
            rd(ADDR_CTRL0, k < 2 ? 8'h00 : 8'h01);
        end
        setup(16'h1000, CMPP_ZERO, 8'hB0);
        wr(ADDR_CTRL0, 8'h08);
        repeat (100) @(posedge clk_sys_i);
        chk("lead", 16'h1, {15'h0, out_pin});
        wr(ADDR_CTRL0, 8'h00);
        repeat (4) @(posedge clk_sys_i);
        chk("trail", 16'h0, {15'h0, out_pin});
        // capture rows: rising, falling, both, disabled with compare P wrap
        for (int pf = 0; pf < 4; pf++)
        begin
            setup(16'hFFFF, pf == 3 ? 8'h01 : CMPP_ZERO,
                8'h40 | 8'(pf << 4) | 8'($urandom & 15));
            wr(ADDR_CTRL0, 8'h08);
            lvl = out_pin;
            irq0 = pins.irq_cnt;
            repeat (40) @(posedge clk_sys_i);
            pins.set_cap(1'b1);
            repeat (40) @(posedge clk_sys_i);
            pins.set_cap(1'b0);
            repeat (pf == 3 ? 1100 : 40) @(posedge clk_sys_i);
            chk("captures", 16'(ci[pf]), 16'(pins.irq_cnt - irq0));
            chk("out hold", {15'h0, lvl}, {15'h0, out_pin});
            rd(ADDR_CMPA_HI, pf == 3 ? 8'hFF : 8'h00);
        end
        repeat (3) @(posedge clk_sys_i);
        results();
    end
endmodule
